// *** logic/adc_calibration_serial_port.sv ***
// Offset/gain correction, calibration and serial host port.
// Assumes the filter runs on ref_clk; serial pins are asynchronous.
// How it works
// [RULE1] Gain word is unsigned; 400000h means gain one, linear.
// [RULE2] Gain word resets to 400000h so data pass unchanged.
// [RULE3] Gain word bytes: low 7..0, mid 15..8, high 23..16.
// [RULE4] Host selects gate mode and runs conversions before calibrating.
// [RULE5] Host applies settled zero or full-scale input before calibration.
// [RULE6] Calibration end drops ready low; that result uses new word.
// [RULE7] Calibration time follows data rate, counted in filter results.
// [RULE8] Host sends no commands while calibration runs.
// [RULE9] Host runs offset calibration before gain calibration.
// [RULE10] Offset calibration uses raw filter output, gain bypassed.
// [RULE11] Out-of-range flag ignores the gain word.
// [RULE12] Link is half-duplex, one direction at a time; in continuous read the port decodes din bytes while data shifts out.
// [RULE13] Transfers framed in bytes of eight clocks.
// [RULE14] Chip select high resets port, ignores input, floats output.
// [RULE15] Host holds chip select low through a whole transaction.
// [RULE16] Serial clock low for 2^16 cycles resets port when enabled.
// [RULE17] Host holds serial clock low when idle.
// [RULE18] Reset/power-down pulse resets the whole block.
// [RULE19] Input bits sampled on serial clock falling edge.
// [RULE20] Output bits change on serial clock rising edge.
// [RULE21] In continuous read, data output mirrors ready while selected.
// [RULE22] Result is (input minus offset) times gain over 400000h.
// [RULE23] Offset word is 24-bit two's complement.
// [RULE24] Result saturates at 7FFFFFh and 800000h.
// [RULE25] Wide arithmetic, product truncated after dividing by unity.
`include "adc_cal_defines.svh"

module adc_calibration_serial_port #(
    parameter int TIMEOUT_CYCLES = `TIMEOUT_CYCLES
) (
    // Clock and reset
    input  logic                   ref_clk,
    input  logic                   rstn,
    input  logic                   reset_powerdown_n,
    // Filter results
    input  adc_cal_pkg::sample_t   filt_sample,
    input  logic                   filt_valid,
    output logic                   filt_ready,
    // Serial pins
    input  logic                   cs_n,
    input  logic                   sclk,
    input  logic                   din,
    output logic                   dout,
    output logic                   dout_oe,
    // Status pins
    output logic                   conversion_ready_n,
    output logic                   out_of_range
);
    logic [1:0]              sclk_s;
    logic [1:0]              csn_s;
    logic [1:0]              din_s;
    logic [1:0]              pd_s;
    logic                    sclk_prev;
    logic                    srst_n;
    logic                    rise;
    logic                    fall;
    logic [16:0]             idle_cnt_q;
    logic                    timeout_hit;
    logic                    port_rst;
    adc_cal_pkg::ser_state_t ser_q;
    logic [4:0]              bit_q;
    logic [7:0]              rx_q;
    logic [7:0]              rx_byte;
    logic                    byte_done;
    logic [2:0]              addr_q;
    logic [7:0]              tx_q;
    logic                    tx_live_q;
    logic                    rdc_q;
    logic                    rdc_active_q;
    logic [23:0]             rdc_sh_q;
    logic                    wr_go;
    logic                    cmd_ok;
    logic                    ofs_cmd;
    logic                    gain_cmd;
    logic [7:0]              cfg_q;
    logic [23:0]             ofs_q;
    logic [23:0]             gain_q;
    logic [7:0]              reg_rd;
    adc_cal_pkg::sample_t    pop_s;
    logic                    pop_valid;
    logic                    pop_go;
    adc_cal_pkg::cal_state_t cal_q;
    logic                    cal_gain_q;
    logic [1:0]              skip_q;
    logic [23:0]             hold_q;
    logic [23:0]             den_q;
    logic [23:0]             quot_q;
    logic [4:0]              idx_q;
    logic [23:0]             trial;
    logic                    ofs_capture;
    logic                    div_done;
    logic [23:0]             result_q;
    logic                    announce_q;
    logic                    dout_d;

    // Two-stage synchronisers for the serial and power-down pins
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            sclk_s    <= 2'h0;
            csn_s     <= 2'h3;
            din_s     <= 2'h0;
            pd_s      <= 2'h3;
            sclk_prev <= 1'b0;
        end else begin
            sclk_s    <= {sclk_s[0], sclk};
            csn_s     <= {csn_s[0], cs_n};
            din_s     <= {din_s[0], din};
            pd_s      <= {pd_s[0], reset_powerdown_n};
            sclk_prev <= sclk_s[1];
        end
    end

    // Block reset and serial clock edges
    assign srst_n = rstn && pd_s[1]; // [RULE18]
    assign rise   = !sclk_prev && sclk_s[1];
    assign fall   = sclk_prev && !sclk_s[1];

    // Idle-low timeout on the serial clock
    always_ff @(posedge ref_clk) begin
        if (!srst_n || sclk_s[1] || csn_s[1] || timeout_hit) begin
            idle_cnt_q <= 17'h0;
        end else begin
            idle_cnt_q <= idle_cnt_q + 17'h1;
        end
    end
    assign timeout_hit = cfg_q[`CFG_TIMEOUT_BIT]
        && (idle_cnt_q == 17'(TIMEOUT_CYCLES - 1)); // [RULE16]
    assign port_rst = csn_s[1] || timeout_hit; // [RULE14] [RULE16]

    // Incoming byte and command decode
    assign rx_byte   = {rx_q[6:0], din_s[1]};
    assign byte_done = fall && (ser_q != adc_cal_pkg::ser_tx)
        && (bit_q == `BYTE_LAST); // [RULE13]
    assign cmd_ok    = byte_done && (ser_q == adc_cal_pkg::ser_cmd)
        && (cal_q == adc_cal_pkg::cal_idle); // [RULE8]
    assign wr_go     = byte_done && (ser_q == adc_cal_pkg::ser_wdata);
    assign ofs_cmd   = cmd_ok && (rx_byte == `CMD_OFS_CAL);
    assign gain_cmd  = cmd_ok && (rx_byte == `CMD_GAIN_CAL);

    // Serial port state machine
    always_ff @(posedge ref_clk) begin
        if (!srst_n || port_rst) begin
            ser_q     <= adc_cal_pkg::ser_cmd;
            bit_q     <= 5'h0;
            rx_q      <= 8'h0;
            addr_q    <= 3'h0;
            tx_q      <= 8'h0;
            tx_live_q <= 1'b0;
        end else begin
            unique case (ser_q)
                adc_cal_pkg::ser_cmd, adc_cal_pkg::ser_wdata: begin
                    if (fall) begin // [RULE19]
                        rx_q  <= rx_byte;
                        bit_q <= byte_done ? 5'h0 : bit_q + 5'h1;
                    end
                    if (wr_go) begin
                        ser_q <= adc_cal_pkg::ser_cmd;
                    end else if (cmd_ok && rx_byte[7:3] == `CMD_WRITE) begin
                        addr_q <= rx_byte[2:0];
                        ser_q  <= adc_cal_pkg::ser_wdata;
                    end else if (cmd_ok && rx_byte[7:3] == `CMD_READ) begin
                        addr_q    <= rx_byte[2:0];
                        tx_live_q <= 1'b0;
                        ser_q     <= adc_cal_pkg::ser_tx;
                    end
                end
                adc_cal_pkg::ser_tx: begin
                    // Input ignored while the device talks
                    if (rise) begin // [RULE12] [RULE20]
                        bit_q <= bit_q + 5'h1;
                        if (!tx_live_q) begin
                            tx_live_q <= 1'b1;
                            tx_q      <= reg_rd;
                        end else begin
                            tx_q <= {tx_q[6:0], 1'b0};
                        end
                    end else if (fall && bit_q == `BYTE_BITS) begin
                        bit_q     <= 5'h0;
                        tx_live_q <= 1'b0;
                        ser_q     <= adc_cal_pkg::ser_cmd;
                    end
                end
            endcase
        end
    end

    // Continuous read mode and its data shifter
    always_ff @(posedge ref_clk) begin
        if (!srst_n) begin
            rdc_q        <= 1'b0;
            rdc_active_q <= 1'b0;
            rdc_sh_q     <= 24'h0;
        end else begin
            if (cmd_ok && rx_byte == `CMD_READ_CONTINUOUS_MODE) begin
                rdc_q <= 1'b1;
            end else if (cmd_ok && rx_byte == `CMD_SDATAC) begin
                rdc_q <= 1'b0;
            end
            if (announce_q || csn_s[1] || !rdc_q) begin
                rdc_active_q <= 1'b0;
                rdc_sh_q     <= result_q;
            end else if (rise && rdc_q && ser_q == adc_cal_pkg::ser_cmd)
            begin // [RULE20]
                if (!rdc_active_q) begin
                    rdc_active_q <= 1'b1;
                end else begin
                    rdc_sh_q <= {rdc_sh_q[22:0], rdc_sh_q[23]};
                end
            end
        end
    end

    // Data output and its enable
    always_comb begin
        dout_d = 1'b0;
        if (ser_q == adc_cal_pkg::ser_tx) begin
            dout_d = tx_live_q && tx_q[7];
        end else if (rdc_q) begin
            dout_d = rdc_active_q ? rdc_sh_q[23]
                                  : conversion_ready_n; // [RULE21]
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!srst_n || csn_s[1]) begin // [RULE14]
            dout    <= 1'b0;
            dout_oe <= 1'b0;
        end else begin
            dout    <= dout_d;
            dout_oe <= 1'b1;
        end
    end

    // Register read multiplexer
    always_comb begin
        unique case (addr_q)
            `ADDR_OFS_LO:   reg_rd = ofs_q[7:0];
            `ADDR_OFS_MID:  reg_rd = ofs_q[15:8];
            `ADDR_OFS_HI:   reg_rd = ofs_q[23:16];
            `ADDR_GAIN_LO:  reg_rd = gain_q[7:0];
            `ADDR_GAIN_MID: reg_rd = gain_q[15:8];
            `ADDR_GAIN_HI:  reg_rd = gain_q[23:16];
            `ADDR_CONFIG:   reg_rd = cfg_q;
            `ADDR_STATUS:   reg_rd = {5'h0, rdc_q,
                                      cal_q != adc_cal_pkg::cal_idle,
                                      conversion_ready_n};
        endcase
    end

    // Configuration register
    always_ff @(posedge ref_clk) begin
        if (!srst_n) begin
            cfg_q <= `CONFIG_RESET;
        end else if (wr_go && addr_q == `ADDR_CONFIG) begin
            cfg_q <= rx_byte;
        end
    end

    // Offset word: byte writes or offset calibration
    always_ff @(posedge ref_clk) begin
        if (!srst_n) begin
            ofs_q <= `OFFSET_ZERO;
        end else if (ofs_capture) begin
            ofs_q <= pop_s.data; // [RULE10] [RULE23]
        end else if (wr_go) begin
            if (addr_q == `ADDR_OFS_LO)  ofs_q[7:0]   <= rx_byte;
            if (addr_q == `ADDR_OFS_MID) ofs_q[15:8]  <= rx_byte;
            if (addr_q == `ADDR_OFS_HI)  ofs_q[23:16] <= rx_byte;
        end
    end

    // Gain word: byte writes or gain calibration
    always_ff @(posedge ref_clk) begin
        if (!srst_n) begin
            gain_q <= `GAIN_UNITY; // [RULE2]
        end else if (div_done) begin
            gain_q <= quot_q;
        end else if (wr_go) begin // [RULE3]
            if (addr_q == `ADDR_GAIN_LO)  gain_q[7:0]   <= rx_byte;
            if (addr_q == `ADDR_GAIN_MID) gain_q[15:8]  <= rx_byte;
            if (addr_q == `ADDR_GAIN_HI)  gain_q[23:16] <= rx_byte;
        end
    end

    // Correction arithmetic with saturation
    function automatic logic [23:0] correct(
        input logic [23:0] raw,
        input logic [23:0] ofs,
        input logic [23:0] gain
    );
        logic signed [24:0] diff;
        logic signed [49:0] prod;
        logic signed [27:0] scaled;
        diff   = signed'({raw[23], raw}) - signed'({ofs[23], ofs});
        prod   = diff * signed'({1'b0, gain}); // [RULE1] [RULE22]
        scaled = prod[49:`GAIN_SHIFT]; // [RULE25]
        if (scaled[27:23] == 5'h00 || scaled[27:23] == 5'h1f) begin
            correct = scaled[23:0];
        end else begin
            correct = scaled[27] ? `NEG_FULL : `POS_FULL; // [RULE24]
        end
    endfunction

    // Results stall while a continuous read shifts out or the divider runs
    assign pop_go = pop_valid && !rdc_active_q
        && (cal_q != adc_cal_pkg::cal_div);
    assign ofs_capture = pop_go && cal_q == adc_cal_pkg::cal_skip
        && skip_q == `CAL_DISCARD && !cal_gain_q;
    assign trial    = quot_q | (24'h1 << idx_q);
    assign div_done = (cal_q == adc_cal_pkg::cal_div)
        && idx_q == `DIV_DONE_IDX; // Bit 0 already decided

    // Calibration sequence and restoring divider
    always_ff @(posedge ref_clk) begin
        if (!srst_n) begin
            cal_q      <= adc_cal_pkg::cal_idle;
            cal_gain_q <= 1'b0;
            skip_q     <= 2'h0;
            hold_q     <= 24'h0;
            den_q      <= 24'h0;
            quot_q     <= 24'h0;
            idx_q      <= 5'h0;
        end else begin
            unique case (cal_q)
                adc_cal_pkg::cal_idle: begin
                    if (ofs_cmd || gain_cmd) begin
                        cal_q      <= adc_cal_pkg::cal_skip;
                        cal_gain_q <= gain_cmd;
                        skip_q     <= 2'h0;
                    end
                end
                adc_cal_pkg::cal_skip: begin
                    if (pop_go && skip_q != `CAL_DISCARD) begin // [RULE7]
                        skip_q <= skip_q + 2'h1;
                    end else if (pop_go && !cal_gain_q) begin
                        cal_q <= adc_cal_pkg::cal_idle;
                    end else if (pop_go) begin
                        hold_q <= pop_s.data;
                        den_q  <= pop_s.data - ofs_q;
                        quot_q <= 24'h0;
                        idx_q  <= `GAIN_TOP_BIT;
                        cal_q  <= adc_cal_pkg::cal_div;
                    end
                end
                adc_cal_pkg::cal_div: begin
                    if (den_q[23] || den_q == 24'h0) begin
                        quot_q <= 24'hffffff;
                        idx_q  <= `DIV_DONE_IDX;
                    end else begin
                        if (48'(trial) * 48'(den_q) <= `CAL_NUMER) begin
                            quot_q <= trial;
                        end
                        idx_q <= idx_q - 5'h1; // Wraps past bit 0
                    end
                    if (div_done) begin
                        cal_q <= adc_cal_pkg::cal_idle;
                    end
                end
                default: cal_q <= adc_cal_pkg::cal_idle;
            endcase
        end
    end

    // Result register, ready flag and out-of-range flag
    always_ff @(posedge ref_clk) begin
        if (!srst_n) begin
            result_q           <= 24'h0;
            announce_q         <= 1'b0;
            conversion_ready_n <= 1'b1;
            out_of_range       <= 1'b0;
        end else begin
            announce_q <= 1'b0;
            if (div_done) begin // [RULE6]
                result_q           <= correct(hold_q, ofs_q, quot_q);
                announce_q         <= 1'b1;
                conversion_ready_n <= 1'b1;
            end else if (pop_go && (cal_q == adc_cal_pkg::cal_idle
                         || ofs_capture)) begin
                result_q           <= correct(pop_s.data,
                    ofs_capture ? pop_s.data : ofs_q, gain_q); // [RULE6]
                out_of_range       <= pop_s.ovr; // [RULE11]
                announce_q         <= 1'b1;
                conversion_ready_n <= 1'b1;
            end else if (announce_q) begin
                conversion_ready_n <= 1'b0;
            end else if (fall && rdc_q && !cfg_q[`CFG_PULSE_BIT]) begin
                conversion_ready_n <= 1'b1;
            end
        end
    end

    // Filter result buffer
    sample_fifo #(
        .WIDTH ($bits(adc_cal_pkg::sample_t)),
        .DEPTH (16)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .rstn      (srst_n),
        .in_data   (filt_sample),
        .in_valid  (filt_valid),
        .in_ready  (filt_ready),
        .out_data  (pop_s),
        .out_valid (pop_valid),
        .out_ready (pop_go)
    );

    // Checks
    a_gain_reset_unity: assert property (@(posedge ref_clk) // [RULE2]
        !srst_n |=> gain_q == `GAIN_UNITY)
        else $error("gain word not unity after reset");
    a_gain_byte_hi: assert property (@(posedge ref_clk) // [RULE3]
        disable iff (!srst_n)
        wr_go && addr_q == `ADDR_GAIN_HI && !div_done
        |=> gain_q[23:16] == $past(rx_byte))
        else $error("gain high byte not written");
    a_unity_pass: assert property (@(posedge ref_clk) // [RULE1]
        disable iff (!srst_n)
        pop_go && cal_q == adc_cal_pkg::cal_idle
        && gain_q == `GAIN_UNITY && ofs_q == `OFFSET_ZERO
        |=> result_q == $past(pop_s.data))
        else $error("unity gain changed the data");
    a_cal_ready_low: assert property (@(posedge ref_clk) // [RULE6]
        disable iff (!srst_n)
        div_done |=> conversion_ready_n ##1 !conversion_ready_n)
        else $error("ready not asserted after calibration");
    a_offset_bypass: assert property (@(posedge ref_clk) // [RULE10]
        disable iff (!srst_n)
        ofs_capture |=> ofs_q == $past(pop_s.data) && result_q == 24'h0)
        else $error("offset capture not raw");
    a_cs_float: assert property (@(posedge ref_clk) // [RULE14]
        csn_s[1] |=> !dout_oe && ser_q == adc_cal_pkg::ser_cmd)
        else $error("port active with chip select high");
    a_timeout_reset: assert property (@(posedge ref_clk) // [RULE16]
        disable iff (!srst_n)
        timeout_hit |=> bit_q == 5'h0 && ser_q == adc_cal_pkg::ser_cmd)
        else $error("timeout did not reset port");
    a_fall_sample: assert property (@(posedge ref_clk) // [RULE19]
        disable iff (!srst_n)
        fall && !port_rst && ser_q != adc_cal_pkg::ser_tx
        |=> rx_q[0] == $past(din_s[1]))
        else $error("input bit not taken on falling edge");
    a_rise_shift: assert property (@(posedge ref_clk) // [RULE20]
        disable iff (!srst_n)
        ser_q == adc_cal_pkg::ser_tx && $past(ser_q) == adc_cal_pkg::ser_tx
        && $changed(dout) |-> $past(rise, 2))
        else $error("output changed without rising edge");
    a_rdc_mirror: assert property (@(posedge ref_clk) // [RULE21]
        disable iff (!srst_n)
        rdc_q && !rdc_active_q && !csn_s[1] && !$past(csn_s[1])
        && ser_q == adc_cal_pkg::ser_cmd
        |=> dout == $past(conversion_ready_n))
        else $error("data output not mirroring ready");
endmodule

// *** logic/adc_cal_defines.svh ***
// Constants for the calibration and serial port block.
// Assumes a single converter clock drives all of the block's logic.
`ifndef ADC_CAL_DEFINES_SVH
`define ADC_CAL_DEFINES_SVH

// Correction words
`define GAIN_UNITY      24'h400000
`define OFFSET_ZERO     24'h000000
`define POS_FULL        24'h7fffff
`define NEG_FULL        24'h800000
`define GAIN_SHIFT      22
`define CAL_NUMER       48'h1fffffc00000
`define GAIN_TOP_BIT    5'h17
`define DIV_DONE_IDX    5'h1f

// Register addresses inside the serial map
`define ADDR_OFS_LO     3'h0
`define ADDR_OFS_MID    3'h1
`define ADDR_OFS_HI     3'h2
`define ADDR_GAIN_LO    3'h3
`define ADDR_GAIN_MID   3'h4
`define ADDR_GAIN_HI    3'h5
`define ADDR_CONFIG     3'h6
`define ADDR_STATUS     3'h7

// Configuration fields and reset value
`define CFG_TIMEOUT_BIT 0
`define CFG_PULSE_BIT   1
`define CONFIG_RESET    8'h00

// Command opcodes
`define CMD_WRITE       5'h08
`define CMD_READ        5'h04
`define CMD_READ_CONTINUOUS_MODE      8'h10
`define CMD_SDATAC      8'h11
`define CMD_OFS_CAL     8'h18
`define CMD_GAIN_CAL    8'h19

// Framing and timing
`define BYTE_LAST       5'h07
`define BYTE_BITS       5'h08
`define CAL_DISCARD     2'h1
`define TIMEOUT_CYCLES  65536

`endif

// *** logic/adc_cal_pkg.sv ***
// Types shared by the calibration and serial port block.
// Assumes the defines header supplies all numeric constants.
package adc_cal_pkg;

    // One filter result with its out-of-range flag
    typedef struct packed {
        logic        ovr;
        logic [23:0] data;
    } sample_t;

    // Serial port phases
    typedef enum logic [1:0] {
        ser_cmd,
        ser_wdata,
        ser_tx
    } ser_state_t;

    // Calibration sequence
    typedef enum logic [1:0] {
        cal_idle,
        cal_skip,
        cal_div
    } cal_state_t;

endpackage

// *** logic/sample_fifo.sv ***
// Synchronous FIFO between the filter and the correction stage.
// Assumes DEPTH is a power of two and one clock for both sides.
module sample_fifo #(
    parameter int WIDTH = 25,
    parameter int DEPTH = 16
) (
    // Clock and synchronous reset
    input  logic             ref_clk,
    input  logic             rstn,
    // Fill side
    input  logic [WIDTH-1:0] in_data,
    input  logic             in_valid,
    output logic             in_ready,
    // Drain side
    output logic [WIDTH-1:0] out_data,
    output logic             out_valid,
    input  logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic [AW:0]      cnt_d;
    logic             push;
    logic             pop;

    // Handshakes and level
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem[rd_q];
    assign cnt_d     = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

    // Storage needs no reset
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    // Pointers, level and registered ready
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            wr_q     <= '0;
            rd_q     <= '0;
            cnt_q    <= '0;
            in_ready <= 1'b0;
        end else begin
            wr_q     <= wr_q + AW'(push);
            rd_q     <= rd_q + AW'(pop);
            cnt_q    <= cnt_d;
            in_ready <= (cnt_d != (AW+1)'(DEPTH));
        end
    end
endmodule

// *** tb/host_model.sv ***
// Serial host model that masters the block's four-wire port.
// Assumes ref_clk is the block clock; sclk half period is 4 cycles.
module host_model (
    // Clock
    input  wire logic ref_clk,
    // Serial pins
    output logic      cs_n,
    output logic      sclk,
    output logic      din,
    input  wire logic dout
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle: deselected, clock low
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        din  = 1'b0;
    end

    // Select or release, held for a whole transaction
    task automatic sel(input logic v);
        @(posedge ref_clk);
        #1 cs_n = v;
    endtask

    // Whole byte, MSB first, din driven and dout sampled in every bit
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            @(posedge ref_clk);
            #1 din = tx[i];
            sclk = 1'b1;
            repeat (4) @(posedge ref_clk);
            #1 sclk = 1'b0;
            repeat (3) @(posedge ref_clk);
            #1 rx[i] = dout; // Before the next rise can move it
        end
        din = ~din; // Not held after the byte
    endtask
endmodule

// *** tb/test_adc_calibration_serial_port.sv ***
// Bench: register and stream checks through the serial host model.
// Assumes the design package, defines header and FIFO are compiled.
`include "adc_cal_defines.svh"
module test_adc_calibration_serial_port;
    timeunit 1ns;
    timeprecision 100ps;
    logic                 ref_clk, rstn, pd_n, filt_valid, filt_ready;
    logic                 cs_n, sclk, din, dout, dout_oe;
    logic                 conversion_ready_n, out_of_range;
    adc_cal_pkg::sample_t filt_sample;
    logic [7:0]           rx, b;
    logic [23:0]          word;
    logic [7:0]           vals [6] = '{8'hf0, 8'hff, 8'hff, 8'h00, 8'h00,
                                       8'h80};
    int                   error_cnt, tests_run, cyc;

    adc_calibration_serial_port #(.TIMEOUT_CYCLES(64))
        adc_calibration_serial_port_inst (
        .ref_clk(ref_clk), .rstn(rstn), .reset_powerdown_n(pd_n),
        .filt_sample(filt_sample), .filt_valid(filt_valid),
        .filt_ready(filt_ready), .cs_n(cs_n), .sclk(sclk), .din(din),
        .dout(dout), .dout_oe(dout_oe),
        .conversion_ready_n(conversion_ready_n),
        .out_of_range(out_of_range));
    host_model host_model_inst (
        .ref_clk(ref_clk), .cs_n(cs_n), .sclk(sclk), .din(din),
        .dout(dout));

    // Clock and cycle ceiling
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 6000) begin
            error_cnt++;
            stop_test();
        end
    end

    // Compare and count
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        host_model_inst.xfer({`CMD_WRITE, a}, rx);
        host_model_inst.xfer(d, rx);
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        host_model_inst.xfer({`CMD_READ, a}, rx);
        host_model_inst.xfer(8'h00, d);
    endtask
    // One filter result offered for one cycle
    task automatic push(input logic [23:0] d, input logic o);
        @(posedge ref_clk);
        #1 filt_sample = '{ovr: o, data: d};
        filt_valid = 1'b1;
        @(posedge ref_clk);
        #1 filt_valid = 1'b0;
    endtask
    // Calibrate: command, discarded and used sample, then ready low
    task automatic cal(input logic [7:0] c, input logic [23:0] d);
        host_model_inst.xfer(c, rx);
        push(d, 1'b0);
        push(d, 1'b0);
        while (conversion_ready_n !== 1'b1) @(posedge ref_clk);
        while (conversion_ready_n !== 1'b0) @(posedge ref_clk);
    endtask
    task automatic stop_test();
        $display("Checks %0d, errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Main sequence
    initial begin
        rstn = 1'b0;
        pd_n = 1'b1;
        filt_valid = 1'b0;
        filt_sample = '0;
        repeat (5) @(posedge ref_clk);
        #1 rstn = 1'b1;
        host_model_inst.sel(1'b0);
        repeat (4) @(posedge ref_clk);
        chk(24'(dout_oe), 24'h1);
        for (int a = 0; a < 6; a++) begin
            rd(a[2:0], b);
            chk(24'(b), (a == 5) ? 24'h40 : 24'h0);
        end
        for (int a = 0; a < 6; a++) wr(a[2:0], vals[a]);
        for (int a = 0; a < 6; a++) begin
            rd(a[2:0], b);
            chk(24'(b), 24'(vals[a]));
        end
        host_model_inst.xfer(`CMD_READ_CONTINUOUS_MODE, rx);
        push(24'h3ffff8, 1'b1);
        while (conversion_ready_n !== 1'b0) @(posedge ref_clk);
        repeat (6) @(posedge ref_clk);
        chk(24'(dout), 24'h0);
        chk(24'(out_of_range), 24'h1);
        for (int i = 0; i < 3; i++) begin
            host_model_inst.xfer(8'h00, rx);
            word = {word[15:0], rx};
        end
        chk(word, 24'h7fffff);
        host_model_inst.xfer(`CMD_SDATAC, rx);
        host_model_inst.sel(1'b1);
        repeat (4) @(posedge ref_clk);
        chk(24'(dout_oe), 24'h0);
        host_model_inst.sel(1'b0);
        wr(3'h6, 8'h01);
        repeat (80) @(posedge ref_clk);
        rd(3'h6, b);
        chk(24'(b), 24'h1);
        cal(`CMD_OFS_CAL, 24'h000123);
        rd(3'h0, b);
        chk(24'(b), 24'h23);
        cal(`CMD_GAIN_CAL, 24'h400123);
        rd(3'h3, b);
        chk(24'(b), 24'hff);
        rd(3'h5, b);
        chk(24'(b), 24'h7f);
        @(posedge ref_clk);
        #1 pd_n = 1'b0;
        repeat (4) @(posedge ref_clk);
        chk(24'(filt_ready), 24'h0);
        #1 pd_n = 1'b1;
        repeat (4) @(posedge ref_clk);
        rd(3'h5, b);
        chk(24'(b), 24'h40);
        push(24'h123456, 1'b0);
        repeat (4) @(posedge ref_clk);
        stop_test();
    end
endmodule
